// ===== rtl/spw_link_watchdog.sv
// Top of the split port link watchdog: configuration registers, millisecond tick, port supervisors, Billboard.
`timescale 1ns/1ps
module spw_link_watchdog #(
	parameter int NUM_PORTS = 2,
	parameter int TICK_CYCLES = spw_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic otpLoad,
	input wire logic [7:0] otpTimeoutSelect,
	input wire logic [7:0] otpPowerOffDuration,
	input wire logic [NUM_PORTS*4-1:0] linkStateStatus,
	output logic [NUM_PORTS-1:0] superspeedHalfPowerPin,
	input wire logic billboardTriggerN,
	output logic billboardConnect,
	input wire logic descRdEn,
	input wire logic [7:0] descIndex,
	output logic [15:0] otpRdAddr,
	input wire logic [7:0] otpRdData,
	output logic [7:0] descData,
	output logic descValid
);

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int LINK_W = 4;

	typedef struct packed {
		logic [TICK_W-1:0] tickCount;
		logic msTick;
		logic [NUM_PORTS-1:0] portSplitEnable;
		logic globalSplitEnable;
		logic [spw_pkg::TIMEOUT_FIELD_W-1:0] timeoutSelect;
		logic [7:0] powerOffDuration;
		logic [7:0] rdData;
		logic bbConnect;
		logic [15:0] otpAddr;
		logic fetchPending;
		logic [7:0] descByte;
		logic descStrobe;
	} spw_top_type;

	// Reset image of the whole state; split enables start off and the timer codes start at their defaults.
	localparam spw_top_type RESET_STATE = '{
		tickCount: '0,
		msTick: 1'b0,
		portSplitEnable: spw_pkg::RST_SPLIT_ENABLE[spw_pkg::SPLIT_ENABLE_FIRST_BIT +: NUM_PORTS],
		globalSplitEnable: spw_pkg::RST_GLOBAL_SPLIT[spw_pkg::GLOBAL_SPLIT_BIT],
		timeoutSelect: spw_pkg::RST_TIMEOUT_SELECT,
		powerOffDuration: spw_pkg::RST_POWER_OFF_DURATION,
		rdData: 8'h00,
		bbConnect: 1'b0,
		otpAddr: 16'h0000,
		fetchPending: 1'b0,
		descByte: 8'h00,
		descStrobe: 1'b0
	};

	typedef struct packed {
		logic splitEn;
		logic globalEn;
		logic timeoutSel;
		logic offDuration;
		logic watchStatus;
	} spw_reg_sel_type;

	// One decoder serves the write and the read path, so both always agree on which register is meant.
	function automatic spw_reg_sel_type decodeAddr(input logic [15:0] addr);
		decodeAddr = '0;
		if (addr == spw_pkg::ADDR_SPLIT_ENABLE) begin
			decodeAddr.splitEn = 1'b1;
		end else if (addr == spw_pkg::ADDR_GLOBAL_SPLIT) begin
			decodeAddr.globalEn = 1'b1;
		end else if (addr == spw_pkg::ADDR_TIMEOUT_SELECT) begin
			decodeAddr.timeoutSel = 1'b1;
		end else if (addr == spw_pkg::ADDR_POWER_OFF_DURATION) begin
			decodeAddr.offDuration = 1'b1;
		end else if (addr == spw_pkg::ADDR_WATCH_STATUS) begin
			decodeAddr.watchStatus = 1'b1;
		end
	endfunction

	spw_top_type q, d;
	logic [NUM_PORTS-1:0] togglingPorts;
	logic [NUM_PORTS-1:0] pins;
	logic [NUM_PORTS-1:0] splitActive;
	spw_reg_sel_type regSel;
	logic [spw_pkg::MS_W-1:0] timeoutLimit;
	logic [spw_pkg::MS_W-1:0] offLimit;

	// One shared divider keeps all timers on a common millisecond grid at the cost of up to 1ms of jitter.
	assign timeoutLimit = spw_pkg::timeoutMs(q.timeoutSelect);
	assign offLimit = spw_pkg::toggleMs(q.powerOffDuration);
	assign regSel = decodeAddr(regAddr);
	// A port needs both its own enable and the global one before its link is watched.
	assign splitActive = q.portSplitEnable & {NUM_PORTS{q.globalSplitEnable}};

	always_comb begin
		d = q;
		d.msTick = 1'b0;
		if (q.tickCount == TICK_W'(TICK_CYCLES - 1)) begin
			d.tickCount = '0;
			d.msTick = 1'b1;
		end else begin
			d.tickCount = q.tickCount + 1'b1;
		end

		// The status register is read-only, so a write to it falls through and changes nothing.
		if (regWrEn) begin
			if (regSel.splitEn) begin
				d.portSplitEnable = regWrData[spw_pkg::SPLIT_ENABLE_FIRST_BIT +: NUM_PORTS];
			end else if (regSel.globalEn) begin
				d.globalSplitEnable = regWrData[spw_pkg::GLOBAL_SPLIT_BIT];
			end else if (regSel.timeoutSel) begin
				d.timeoutSelect = regWrData[spw_pkg::TIMEOUT_FIELD_W-1:0];
			end else if (regSel.offDuration) begin
				d.powerOffDuration = regWrData;
			end
		end
		// An OTP load is the later configuration source, so it wins over a timeout select or power-off duration write in the same cycle.
		if (otpLoad) begin
			d.timeoutSelect = otpTimeoutSelect[spw_pkg::TIMEOUT_FIELD_W-1:0];
			d.powerOffDuration = otpPowerOffDuration;
		end

		// Reserved bits read as zero because nothing is stored behind them.
		if (regRdEn) begin
			d.rdData = 8'h00;
			if (regSel.splitEn) begin
				d.rdData[spw_pkg::SPLIT_ENABLE_FIRST_BIT +: NUM_PORTS] = q.portSplitEnable;
			end else if (regSel.globalEn) begin
				d.rdData[spw_pkg::GLOBAL_SPLIT_BIT] = q.globalSplitEnable;
			end else if (regSel.timeoutSel) begin
				d.rdData[spw_pkg::TIMEOUT_FIELD_W-1:0] = q.timeoutSelect;
			end else if (regSel.offDuration) begin
				d.rdData = q.powerOffDuration;
			end else if (regSel.watchStatus) begin
				d.rdData[NUM_PORTS-1:0] = togglingPorts;
			end
		end

		d.bbConnect = !billboardTriggerN;

		d.descStrobe = 1'b0;
		if (q.fetchPending) begin
			d.descByte = otpRdData;
			d.descStrobe = 1'b1;
			d.fetchPending = 1'b0;
		end
		if (descRdEn && q.bbConnect) begin
			d.otpAddr = spw_pkg::OTP_MESSAGE_BASE + 16'(descIndex);
			d.fetchPending = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	generate
		for (genvar i = 0; i < NUM_PORTS; i++) begin : gPort
			spw_port_supervisor uSup (
				.clk(clk),
				.rst(rst),
				.msTick(q.msTick),
				.splitActive(splitActive[i]),
				.timeoutLimit(timeoutLimit),
				.offLimit(offLimit),
				.linkState(linkStateStatus[i*LINK_W +: LINK_W]),
				.powerPin(pins[i]),
				.toggling(togglingPorts[i])
			);
		end
	endgenerate

	assign superspeedHalfPowerPin = pins;
	assign regRdData = q.rdData;
	assign billboardConnect = q.bbConnect;
	assign otpRdAddr = q.otpAddr;
	assign descData = q.descByte;
	assign descValid = q.descStrobe;

endmodule // spw_link_watchdog

// ===== rtl/spw_pkg.sv
// Package with register map, reset values and timing constants of the split port link watchdog.
package spw_pkg;

	localparam logic [15:0] ADDR_SPLIT_ENABLE = 16'h3c48;
	localparam logic [15:0] ADDR_GLOBAL_SPLIT = 16'h4141;
	localparam logic [15:0] ADDR_TIMEOUT_SELECT = 16'h4171;
	localparam logic [15:0] ADDR_POWER_OFF_DURATION = 16'h4176;
	localparam logic [15:0] ADDR_WATCH_STATUS = 16'h41f0;

	localparam logic [7:0] RST_SPLIT_ENABLE = 8'h00;
	localparam logic [7:0] RST_GLOBAL_SPLIT = 8'h00;
	localparam logic [2:0] RST_TIMEOUT_SELECT = 3'h5;
	localparam logic [7:0] RST_POWER_OFF_DURATION = 8'h05;

	localparam int SPLIT_ENABLE_FIRST_BIT = 5;
	localparam int GLOBAL_SPLIT_BIT = 0;
	localparam int TIMEOUT_FIELD_W = 3;

	localparam logic [3:0] LINK_STUCK_LOW = 4'h4;
	localparam logic [3:0] LINK_STUCK_HIGH = 4'h9;

	localparam int MS_W = 12;
	localparam logic [MS_W-1:0] TIMEOUT_100MS = 12'h064;
	localparam logic [MS_W-1:0] TIMEOUT_250MS = 12'h0fa;
	localparam logic [MS_W-1:0] TIMEOUT_750MS = 12'h2ee;
	localparam logic [MS_W-1:0] TIMEOUT_1S = 12'h3e8;
	localparam logic [MS_W-1:0] TIMEOUT_2S = 12'h7d0;
	localparam logic [MS_W-1:0] TIMEOUT_NONE = 12'h000;
	localparam logic [MS_W-1:0] TOGGLE_BASE_MS = 12'h15e;
	localparam logic [MS_W-1:0] TOGGLE_STEP_MS = 12'h00a;

	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_TIME_NS = 1000000;
	localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [15:0] OTP_MESSAGE_BASE = 16'h1000;

	// Code 101b also selects one second so that the reset value gives the documented default.
	function automatic logic [MS_W-1:0] timeoutMs(input logic [TIMEOUT_FIELD_W-1:0] code);
		case (code)
			3'h1: timeoutMs = TIMEOUT_100MS;
			3'h2: timeoutMs = TIMEOUT_250MS;
			3'h3: timeoutMs = TIMEOUT_750MS;
			3'h4: timeoutMs = TIMEOUT_1S;
			3'h5: timeoutMs = TIMEOUT_1S;
			3'h6: timeoutMs = TIMEOUT_2S;
			default: timeoutMs = TIMEOUT_NONE;
		endcase
	endfunction

	function automatic logic [MS_W-1:0] toggleMs(input logic [7:0] code);
		toggleMs = TOGGLE_BASE_MS + MS_W'(code) * TOGGLE_STEP_MS;
	endfunction

	typedef enum logic [1:0] {
		SPW_WATCH = 2'b01,
		SPW_POWER_OFF = 2'b10
	} spw_port_state_type;

endpackage

// ===== rtl/spw_port_supervisor.sv
// Per-port link supervisor that power-cycles an embedded device whose link is stuck.
`timescale 1ns/1ps
module spw_port_supervisor (
	input wire logic clk,
	input wire logic rst,
	input wire logic msTick,
	input wire logic splitActive,
	input wire logic [spw_pkg::MS_W-1:0] timeoutLimit,
	input wire logic [spw_pkg::MS_W-1:0] offLimit,
	input wire logic [3:0] linkState,
	output logic powerPin,
	output logic toggling
);

	typedef struct packed {
		spw_pkg::spw_port_state_type state;
		logic [spw_pkg::MS_W-1:0] count;
		logic [3:0] lastState;
		logic pin;
	} spw_sup_type;

	spw_sup_type q, d;
	logic stuck;

	always_comb begin
		d = q;
		stuck = (linkState >= spw_pkg::LINK_STUCK_LOW) && (linkState <= spw_pkg::LINK_STUCK_HIGH);
		d.lastState = linkState;
		case (q.state)
			spw_pkg::SPW_WATCH: begin
				d.pin = 1'b1;
				if (!splitActive || timeoutLimit == spw_pkg::TIMEOUT_NONE) begin
					d.count = '0;
				end else if (!stuck || linkState != q.lastState) begin
					d.count = '0;
				end else if (msTick) begin
					if (q.count + 1'b1 >= timeoutLimit) begin
						d.count = '0;
						d.state = spw_pkg::SPW_POWER_OFF;
						d.pin = 1'b0;
					end else begin
						d.count = q.count + 1'b1;
					end
				end
			end
			spw_pkg::SPW_POWER_OFF: begin
				d.pin = 1'b0;
				if (msTick) begin
					if (q.count + 1'b1 >= offLimit) begin
						d.count = '0;
						d.state = spw_pkg::SPW_WATCH;
						d.pin = 1'b1;
					end else begin
						d.count = q.count + 1'b1;
					end
				end
			end
			default: begin
				d.state = spw_pkg::SPW_WATCH;
				d.count = '0;
				d.pin = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{state: spw_pkg::SPW_WATCH, count: '0, lastState: 4'h0, pin: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign powerPin = q.pin;
	assign toggling = (q.state == spw_pkg::SPW_POWER_OFF);

endmodule // spw_port_supervisor

// ===== tb/spw_power_switch_model.sv
// Power switch and embedded device link model at the far side of one split port.
`timescale 1ns/1ps
module spw_power_switch_model (
	input wire logic clk,
	input wire logic powerPin,
	input wire logic healthy,
	input wire logic [3:0] stuckCode,
	output logic [3:0] linkState
);
	logic [1:0] walk = 2'h0;
	always @(posedge clk) begin
		walk <= walk + 2'h1;
	end
	// Without power the device cannot answer, so the hub keeps looking for a receiver.
	assign linkState = !powerPin ? 4'h5 : healthy ? {2'h0, walk} : stuckCode;
endmodule // spw_power_switch_model

// ===== tb/spw_link_watchdog_assertions.sv
// Concurrent checks on the ports of the split port link watchdog.
`timescale 1ns/1ps
module spw_link_watchdog_assertions #(
	parameter int NUM_PORTS = 2,
	parameter int TICK_CYCLES = spw_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic [NUM_PORTS*4-1:0] linkStateStatus,
	input wire logic [NUM_PORTS-1:0] superspeedHalfPowerPin,
	input wire logic billboardTriggerN,
	input wire logic billboardConnect,
	input wire logic descRdEn,
	input wire logic [7:0] descIndex,
	input wire logic [15:0] otpRdAddr,
	input wire logic [7:0] otpRdData,
	input wire logic [7:0] descData,
	input wire logic descValid
);
	int lowCnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence descReq;
		descRdEn && billboardConnect;
	endsequence
	// Low time is counted in clocks, since the tick phase cannot be seen at the ports.
	always_ff @(posedge clk) begin
		lowCnt_q <= (rst || superspeedHalfPowerPin[0]) ? 0 : lowCnt_q + 1;
	end
	pins_idle_a: assert property ($fell(rst) |-> &superspeedHalfPowerPin)
		else $error("power pin low after reset");
	fall_cause_a: assert property ($fell(superspeedHalfPowerPin[0]) |-> $past(linkStateStatus[3:0]) inside {[4:9]})
		else $error("power pin fell without a stuck link");
	low_time_a: assert property ($rose(superspeedHalfPowerPin[0]) |-> lowCnt_q >= 350 * TICK_CYCLES)
		else $error("power pin low time too short");
	bb_follow_a: assert property (!$past(rst) |-> billboardConnect == !$past(billboardTriggerN))
		else $error("billboard connect does not follow trigger");
	desc_addr_a: assert property (descReq |=> otpRdAddr == spw_pkg::OTP_MESSAGE_BASE + 16'($past(descIndex)))
		else $error("wrong message address");
	desc_data_a: assert property (descReq |=> ##1 descValid && descData == $past(otpRdData))
		else $error("wrong descriptor byte");
	desc_idle_a: assert property (!(descRdEn && billboardConnect) |=> ##1 !descValid)
		else $error("descriptor byte without request");
	rd_hold_a: assert property (!regRdEn |=> $stable(regRdData))
		else $error("read data changed without read");
endmodule // spw_link_watchdog_assertions

bind spw_link_watchdog spw_link_watchdog_assertions #(.NUM_PORTS(NUM_PORTS), .TICK_CYCLES(TICK_CYCLES)) chk (
	.clk(clk), .rst(rst), .regRdEn(regRdEn), .regRdData(regRdData), .linkStateStatus(linkStateStatus),
	.superspeedHalfPowerPin(superspeedHalfPowerPin), .billboardTriggerN(billboardTriggerN),
	.billboardConnect(billboardConnect), .descRdEn(descRdEn), .descIndex(descIndex), .otpRdAddr(otpRdAddr),
	.otpRdData(otpRdData), .descData(descData), .descValid(descValid));

// ===== tb/spw_link_watchdog_bench.sv
// Self-checking bench of the split port link watchdog with far-side device models.
`timescale 1ns/1ps
module spw_link_watchdog_bench;
	localparam int T = 4;
	logic clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, otpLoad = 0, billboardTriggerN = 1, descRdEn = 0;
	logic [15:0] regAddr = 0, otpRdAddr;
	logic [7:0] regWrData = 0, otpTo = 0, otpOff = 0, descIndex = 0, regRdData, descData, lss;
	logic [1:0] pin, healthy = 2'b11;
	logic [3:0] stuck = 4'h4;
	logic billboardConnect, descValid;
	int err_total = 0, tests_run = 0, n, d;
	// Timeout of each select code in ticks, kept apart from the design's own decoder.
	int toMs[8] = '{0, 100, 250, 750, 1000, 1000, 2000, 0};
	int codes[$] = '{2, 3, 4, 5, 6, 7};
	always #2.5 clk = ~clk;
	spw_link_watchdog #(.NUM_PORTS(2), .TICK_CYCLES(T)) spw_link_watchdog_inst (.clk(clk), .rst(rst),
		.regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.otpLoad(otpLoad), .otpTimeoutSelect(otpTo), .otpPowerOffDuration(otpOff), .linkStateStatus(lss),
		.superspeedHalfPowerPin(pin), .billboardTriggerN(billboardTriggerN), .billboardConnect(billboardConnect),
		.descRdEn(descRdEn), .descIndex(descIndex), .otpRdAddr(otpRdAddr), .otpRdData(otpRdAddr[7:0] ^ 8'h5a),
		.descData(descData), .descValid(descValid));
	spw_power_switch_model sw0 (.clk(clk), .powerPin(pin[0]), .healthy(healthy[0]), .stuckCode(stuck),
		.linkState(lss[3:0]));
	spw_power_switch_model sw1 (.clk(clk), .powerPin(pin[1]), .healthy(healthy[1]), .stuckCode(stuck),
		.linkState(lss[7:4]));
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chkR(input int g, input int lo, input int hi);
		chk(16'(g), (g >= lo && g <= hi) ? 16'(g) : 16'(lo));
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regWrData <= v;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1 chk(16'(regRdData), 16'(e));
	endtask
	// Bounded wait, so a pin that never moves ends the run instead of hanging it.
	task automatic waitPin(input logic v, output int c);
		c = 0;
		while (pin[0] !== v) begin
			@(posedge clk);
			#1 c++;
			if (c > 20000) begin
				err_total++;
				summarize();
			end
		end
	endtask
	task automatic quiet(input int cyc, output int lows);
		lows = 0;
		repeat (cyc) begin
			@(posedge clk);
			#1 lows += int'(pin !== 2'b11);
		end
	endtask
	initial begin
		void'($urandom(95));
		stuck = 4'h4 + 4'($urandom_range(5));
		d = $urandom_range(3);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(16'h4171, 8'h05);
		rd(16'h4176, 8'h05);
		rd(16'h2000, 8'h00);
		wr(16'h4171, 8'hf9);
		rd(16'h4171, 8'h01);
		wr(16'h4176, 8'(d));
		wr(16'h3c48, 8'hff);
		rd(16'h3c48, 8'h60);
		@(posedge clk) healthy <= 2'b10;
		quiet(600, n);
		chk(16'(n), 16'h0);
		wr(16'h4141, 8'h01);
		for (int i = 0; i < 2; i++) begin
			waitPin(1'b0, n);
			chkR(n, 99 * T, 102 * T);
			rd(16'h41f0, 8'h01);
			waitPin(1'b1, n);
			chkR(n, (349 + 10 * d) * T, (351 + 10 * d) * T);
		end
		@(posedge clk) healthy <= 2'b11;
		quiet(600, n);
		chk(16'(n), 16'h0);
		rd(16'h41f0, 8'h00);
		rd(16'h4141, 8'h01);
		foreach (codes[k]) begin
			wr(16'h4171, 8'(codes[k]));
			@(posedge clk) healthy <= 2'b10;
			if (toMs[codes[k]] == 0) begin
				quiet(9000, n);
				chk(16'(n), 16'h0);
			end else begin
				waitPin(1'b0, n);
				chkR(n, (toMs[codes[k]] - 1) * T, (toMs[codes[k]] + 1) * T);
				waitPin(1'b1, n);
				chkR(n, (349 + 10 * d) * T, (351 + 10 * d) * T);
			end
			@(posedge clk) healthy <= 2'b11;
		end
		@(posedge clk) otpOff <= 8'($urandom);
		otpLoad <= 1'b1;
		@(posedge clk) otpLoad <= 1'b0;
		rd(16'h4171, 8'h00);
		rd(16'h4176, otpOff);
		@(posedge clk) healthy <= 2'b10;
		quiet(600, n);
		chk(16'(n), 16'h0);
		@(posedge clk) billboardTriggerN <= 1'b0;
		@(posedge clk) descIndex <= 8'($urandom);
		#1 chk(16'(billboardConnect), 16'h1);
		@(posedge clk) descRdEn <= 1'b1;
		@(posedge clk) descRdEn <= 1'b0;
		@(posedge clk);
		#1 chk({descValid, 7'h0, descData}, {8'h80, descIndex ^ 8'h5a});
		summarize();
	end
endmodule // spw_link_watchdog_bench
